// *** core/gain_switch.sv ***
`timescale 1ns/1ps
module gain_switch
	import gain_switch_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic host_gain_select_bit,
	input wire motion_status_t motion,
	output gain_out_t gains,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic [23:0] mag(input logic signed [23:0] v);
		mag = v[23] ? 24'(-v) : 24'(v);
	endfunction

	// ---------------- register file ----------------
	logic enable_r, enable_nxt;
	logic [3:0] mode_r, mode_nxt;
	logic [13:0] delay_r, delay_nxt;
	logic [14:0] level_r, level_nxt;
	logic [14:0] hyst_r, hyst_nxt;
	logic [13:0] ramp_r, ramp_nxt;
	logic [15:0] gain1_r, gain1_nxt;
	logic [15:0] gain2_r, gain2_nxt;
	logic aw_full_r, aw_full_nxt;
	logic w_full_r, w_full_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] status_word;
	logic [31:0] wr_word;
	logic [31:0] cur_word;
	logic wr_hit;

	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready = !w_full_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	gain_set_t set_r, set_nxt;
	logic [15:0] gain_r, gain_nxt;
	logic p_only_r, p_only_nxt;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STATUS_SECOND_BIT] = (set_r == SET_SECOND);
		status_word[STATUS_P_ONLY_BIT] = p_only_r;
		status_word[STATUS_GAIN_LSB +: 16] = gain_r;
	end

	always_comb begin
		enable_nxt = enable_r;
		mode_nxt = mode_r;
		delay_nxt = delay_r;
		level_nxt = level_r;
		hyst_nxt = hyst_r;
		ramp_nxt = ramp_r;
		gain1_nxt = gain1_r;
		gain2_nxt = gain2_r;
		aw_full_nxt = aw_full_r;
		w_full_nxt = w_full_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		cur_word = 32'h0000_0000;
		wr_word = 32'h0000_0000;
		wr_hit = 1'b1;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		// both halves held: commit the write one cycle after the later one arrives
		if (aw_full_r && w_full_r) begin
			unique case ({awaddr_r[7:2], 2'b00})
				CTRL_OFFSET: cur_word = 32'({mode_r, 3'b000, enable_r});
				DELAY_OFFSET: cur_word = 32'(delay_r);
				LEVEL_OFFSET: cur_word = 32'(level_r);
				HYST_OFFSET: cur_word = 32'(hyst_r);
				RAMP_OFFSET: cur_word = 32'(ramp_r);
				GAIN1_OFFSET: cur_word = 32'(gain1_r);
				GAIN2_OFFSET: cur_word = 32'(gain2_r);
				default: wr_hit = 1'b0;
			endcase
			for (int b = 0; b < 4; b++) begin
				wr_word[8*b +: 8] = wstrb_r[b] ? wdata_r[8*b +: 8] : cur_word[8*b +: 8];
			end
			if (wr_hit) begin
				unique case ({awaddr_r[7:2], 2'b00})
					CTRL_OFFSET: begin
						enable_nxt = wr_word[CTRL_ENABLE_BIT];
						mode_nxt = wr_word[CTRL_MODE_LSB +: 4];
					end
					DELAY_OFFSET: delay_nxt = wr_word[13:0];
					LEVEL_OFFSET: level_nxt = wr_word[14:0];
					HYST_OFFSET: hyst_nxt = wr_word[14:0];
					RAMP_OFFSET: ramp_nxt = wr_word[13:0];
					GAIN1_OFFSET: gain1_nxt = wr_word[15:0];
					default: gain2_nxt = wr_word[15:0];
				endcase
			end
			aw_full_nxt = 1'b0;
			w_full_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				CTRL_OFFSET: rdata_nxt = 32'({mode_r, 3'b000, enable_r});
				DELAY_OFFSET: rdata_nxt = 32'(delay_r);
				LEVEL_OFFSET: rdata_nxt = 32'(level_r);
				HYST_OFFSET: rdata_nxt = 32'(hyst_r);
				RAMP_OFFSET: rdata_nxt = 32'(ramp_r);
				GAIN1_OFFSET: rdata_nxt = 32'(gain1_r);
				GAIN2_OFFSET: rdata_nxt = 32'(gain2_r);
				STATUS_OFFSET: rdata_nxt = status_word;
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_r <= 1'b0;
			mode_r <= MODE_RESET;
			delay_r <= DELAY_RESET;
			level_r <= LEVEL_RESET;
			hyst_r <= HYST_RESET;
			ramp_r <= RAMP_RESET;
			gain1_r <= GAIN1_RESET;
			gain2_r <= GAIN2_RESET;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			enable_r <= enable_nxt;
			mode_r <= mode_nxt;
			delay_r <= delay_nxt;
			level_r <= level_nxt;
			hyst_r <= hyst_nxt;
			ramp_r <= ramp_nxt;
			gain1_r <= gain1_nxt;
			gain2_r <= gain2_nxt;
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ---------------- 0.1 ms tick ----------------
	logic [31:0] div_r, div_nxt;
	logic tick;

	assign tick = (div_r == 32'(TICK_COUNT - 1));

	always_comb begin
		div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
	end

	// ---------------- trigger and set selection ----------------
	logic [14:0] hyst_eff;
	logic [23:0] upper, lower, sample;
	logic above, below, level_mode;
	logic enter, release_ok, timed_return;
	logic [13:0] hold_r, hold_nxt;

	always_comb begin
		hyst_eff = (hyst_r > level_r) ? level_r : hyst_r;
		upper = 24'(level_r) + 24'(hyst_eff);
		lower = 24'(level_r) - 24'(hyst_eff);
		unique case (mode_r)
			MODE_THRUST: sample = mag(motion.thrust_cmd);
			MODE_VEL_CMD: sample = mag(motion.velocity_cmd);
			MODE_DEVIATION: sample = mag(motion.position_deviation);
			default: sample = mag(motion.actual_speed);
		endcase
		above = sample > upper;
		below = sample < lower;
		level_mode = 1'b0;
		enter = 1'b0;
		release_ok = 1'b1;
		unique case (mode_r)
			MODE_THRUST, MODE_VEL_CMD, MODE_DEVIATION, MODE_SPEED: begin
				level_mode = 1'b1;
				enter = above;
				release_ok = below;
			end
			MODE_CMD_PRESENT: begin
				enter = motion.position_cmd_present;
				release_ok = !motion.position_cmd_present;
			end
			MODE_NOT_SETTLED: begin
				enter = !motion.positioning_complete;
				release_ok = motion.positioning_complete;
			end
			MODE_CMD_AND_SPEED: begin
				level_mode = 1'b1;
				enter = motion.position_cmd_present || above;
				release_ok = !motion.position_cmd_present && below;
			end
			default: begin
				enter = 1'b0;
				release_ok = 1'b1;
			end
		endcase
		timed_return = level_mode || mode_r == MODE_CMD_PRESENT || mode_r == MODE_NOT_SETTLED;
		hold_nxt = hold_r;
		set_nxt = set_r;
		p_only_nxt = 1'b0;
		if (!enable_r) begin
			set_nxt = SET_FIRST;
			p_only_nxt = host_gain_select_bit;
			hold_nxt = 14'h0000;
		end else begin
			unique case (mode_r)
				MODE_FIX_FIRST, MODE_INVALID: set_nxt = SET_FIRST;
				MODE_FIX_SECOND: set_nxt = SET_SECOND;
				MODE_HOST_BIT: set_nxt = host_gain_select_bit ? SET_SECOND : SET_FIRST;
				default: begin
					if (!timed_return) begin
						set_nxt = SET_FIRST;
					end else if (set_r == SET_FIRST) begin
						hold_nxt = 14'h0000;
						if (enter) begin
							set_nxt = SET_SECOND;
						end
					end else if (!release_ok) begin
						// any excursion restarts the return delay
						hold_nxt = 14'h0000;
					end else if (hold_r >= delay_r) begin
						set_nxt = SET_FIRST;
						hold_nxt = 14'h0000;
					end else if (tick) begin
						hold_nxt = hold_r + 14'h0001;
					end
				end
			endcase
		end
	end

	// ---------------- gain ramp ----------------
	logic [15:0] target, diff_r, diff_nxt, last_target_r;
	logic [31:0] acc_r, acc_nxt, span, acc_sum;

	always_comb begin
		target = (set_r == SET_SECOND) ? gain2_r : gain1_r;
		span = 32'(ramp_r * TICK_COUNT);
		acc_sum = acc_r + 32'(diff_r);
		gain_nxt = gain_r;
		acc_nxt = acc_r;
		diff_nxt = diff_r;
		if (target != last_target_r) begin
			diff_nxt = (target > gain_r) ? target - gain_r : 16'h0000;
			acc_nxt = 32'h0000_0000;
		end
		if (target <= gain_r || ramp_r == 14'h0000) begin
			gain_nxt = target;
		end else if (acc_sum >= span) begin
			// spread the rise over span cycles; one step a cycle at most
			acc_nxt = acc_sum - span;
			gain_nxt = gain_r + 16'h0001;
		end else begin
			acc_nxt = acc_sum;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_r <= 32'h0000_0000;
			hold_r <= 14'h0000;
			set_r <= SET_FIRST;
			p_only_r <= 1'b0;
			gain_r <= GAIN1_RESET;
			diff_r <= 16'h0000;
			acc_r <= 32'h0000_0000;
			last_target_r <= GAIN1_RESET;
		end else begin
			div_r <= div_nxt;
			hold_r <= hold_nxt;
			set_r <= set_nxt;
			p_only_r <= p_only_nxt;
			gain_r <= gain_nxt;
			diff_r <= diff_nxt;
			acc_r <= acc_nxt;
			last_target_r <= target;
		end
	end

	assign gains.second_set_active = (set_r == SET_SECOND);
	assign gains.velocity_p_only = p_only_r;
	assign gains.position_loop_gain = gain_r;

endmodule

// *** dv/gain_switch_properties.sv ***
`timescale 1ns/1ps
module gain_switch_properties
	import gain_switch_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic host_gain_select_bit,
	input wire gain_out_t gains,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_p_only_source: assert property (gains.velocity_p_only |-> $past(host_gain_select_bit))
		else $error("p only raised without host bit");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("write response not held");
	a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read data not held");
endmodule
bind gain_switch gain_switch_properties i_props (.clk(clk), .sys_rst(sys_rst),
	.host_gain_select_bit(host_gain_select_bit), .gains(gains),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** dv/host_model.sv ***
`timescale 1ns/1ps
module host_model
	import gain_switch_pkg::*;
(
	input wire logic clk,
	output logic host_gain_select_bit,
	output motion_status_t motion
);
	initial begin
		host_gain_select_bit = 1'b0;
		motion = '0;
		motion.positioning_complete = 1'b1;
	end
	// only the quantity that the mode watches moves; the rest idles settled
	task drive(input logic hb, input logic [3:0] mode, input int v);
		motion_status_t m;
		m = '0;
		m.positioning_complete = 1'b1;
		case (mode)
			4'h3: m.thrust_cmd = v[23:0];
			4'h5: m.velocity_cmd = v[23:0];
			4'h6: m.position_deviation = v[23:0];
			4'h7, 4'ha: m.position_cmd_present = (v != 0);
			4'h8: m.positioning_complete = (v == 0);
			4'h9: m.actual_speed = v[23:0];
			default: ;
		endcase
		// new levels land just after a rising edge, like any other bench stimulus
		@(posedge clk);
		host_gain_select_bit <= hb;
		motion <= m;
	endtask
endmodule

// *** dv/servo_gain_set_switcher_bench.sv ***
`timescale 1ns/1ps
module servo_gain_set_switcher_bench
	import gain_switch_pkg::*;
;
	logic clk, sys_rst, hb, awv, awr, wv, wr_r, bv, brdy, arv, arr, rv, rrdy;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [3:0] ws;
	logic [1:0] bresp, rresp, r;
	motion_status_t motion;
	gain_out_t gains;
	int n_errors, n_checks, cycles;
	host_model i_host (.clk(clk), .host_gain_select_bit(hb), .motion(motion));
	gain_switch #(.TICK_COUNT(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.host_gain_select_bit(hb), .motion(motion), .gains(gains),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end
	task w(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// handshakes are judged at the rising edge, before that edge's register updates land;
	// ready goes up one cycle late so that the hold checks see a waiting answer
	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awa <= a; wd <= v; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_r) wv <= 1'b0;
		end while (!bv);
		brdy <= 1'b1;
		@(posedge clk);
		r = bresp;
		brdy <= 1'b0;
	endtask
	task rreg(input logic [7:0] a);
		@(posedge clk);
		ara <= a; arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		rrdy <= 1'b1;
		@(posedge clk);
		d = rdat;
		r = rresp;
		rrdy <= 1'b0;
	endtask
	task cfg(input logic [3:0] m, input logic en);
		wreg(CTRL_OFFSET, {24'h0, m, 3'h0, en});
	endtask
	task t_regs();
		rreg(CTRL_OFFSET); chk(d, 0); chk(r, RESP_OKAY);
		wreg(LEVEL_OFFSET, 32'hffffffff); rreg(LEVEL_OFFSET); chk(d, 32'h7fff);
		rreg(8'h20); chk(r, RESP_SLVERR); chk(d, 0);
		wreg(STATUS_OFFSET, 32'h1); chk(r, RESP_SLVERR);
		$display("registers done");
	endtask
	task t_disabled();
		cfg(4'h1, 1'b0); i_host.drive(1, 0, 0);
		w(3); chk(gains.second_set_active, 0); chk(gains.velocity_p_only, 1);
		rreg(STATUS_OFFSET); chk(d[1:0], 2'b10);
		i_host.drive(0, 0, 0); w(3); chk(gains.velocity_p_only, 0);
		$display("disabled done");
	endtask
	task t_fixed();
		logic [3:0] m;
		i_host.drive(1, 0, 0);
		for (int i = 0; i < 3; i++) begin
			m = (i == 2) ? 4'h4 : i[3:0];
			cfg(m, 1'b1); w(3);
			chk(gains.second_set_active, m == 4'h1);
			chk(gains.velocity_p_only, 0);
		end
		cfg(4'h2, 1'b1);
		for (int i = 0; i < 3; i++) begin
			i_host.drive(i == 1, 0, 0); w(3);
			chk(gains.second_set_active, i == 1);
		end
		$display("fixed and host modes done");
	endtask
	task t_thrust();
		wreg(LEVEL_OFFSET, 100); wreg(HYST_OFFSET, 300); wreg(DELAY_OFFSET, 3);
		cfg(4'h3, 1'b1);
		i_host.drive(0, 3, 200); w(3); chk(gains.second_set_active, 0);
		i_host.drive(0, 3, -201); w(3); chk(gains.second_set_active, 1);
		wreg(HYST_OFFSET, 30);
		i_host.drive(0, 3, 70); w(20); chk(gains.second_set_active, 1);
		i_host.drive(0, 3, 69); w(6); chk(gains.second_set_active, 1);
		w(16); chk(gains.second_set_active, 0);
		$display("thrust done");
	endtask
	task t_triggers();
		wreg(DELAY_OFFSET, 0);
		for (int m = 5; m <= 10; m++) begin
			cfg(m[3:0], 1'b1);
			i_host.drive(0, m[3:0], 0); w(3); chk(gains.second_set_active, 0);
			i_host.drive(0, m[3:0], 500); w(3); chk(gains.second_set_active, 1);
			i_host.drive(0, m[3:0], 0); w(3); chk(gains.second_set_active, 0);
		end
		$display("triggers done");
	endtask
	task t_ramp();
		cfg(4'h0, 1'b1); wreg(RAMP_OFFSET, 0); wreg(GAIN1_OFFSET, 10); wreg(GAIN2_OFFSET, 15);
		w(3); chk(gains.position_loop_gain, 10);
		wreg(RAMP_OFFSET, 5); cfg(4'h1, 1'b1);
		w(2); chk(gains.position_loop_gain < 16'd15, 1);
		w(30); chk(gains.position_loop_gain, 15);
		cfg(4'h0, 1'b1); w(3); chk(gains.position_loop_gain, 10);
		$display("ramp done");
	endtask
	initial begin
		sys_rst = 1; awv = 0; wv = 0; brdy = 0; arv = 0; rrdy = 0;
		awa = 0; ara = 0; wd = 0; ws = 0; n_errors = 0; n_checks = 0; cycles = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		t_regs();
		t_disabled();
		t_fixed();
		t_thrust();
		t_triggers();
		t_ramp();
		end_of_test();
	end
endmodule

// *** pkg/gain_switch_pkg.sv ***
// How it works
// - with second_gain_enable at 0 the first gain set stays in use, and host_gain_select_bit picks PI (0) or P only (1) for the velocity loop.
// - with second_gain_enable at 1 the block may switch between the first and the second gain set as the trigger mode says.
// - position_switch_trigger_mode 0 fixes the first set, 1 the second, 2 follows the host bit and 3 triggers on the thrust command.
// - mode 4 keeps the first set; modes 5 to 10 trigger on velocity command, deviation, command present, not settled, speed, and command present plus speed.
// - in modes 3 and 5 to 10 the return from the second set to the first waits position_switch_return_delay ticks of 0.1 ms.
// - modes 3, 5, 6, 9 and 10 compare a magnitude with position_switch_level.
// - position_switch_hysteresis widens the band around the level and is limited to the level when larger.
// - a rising position loop gain ramps to its new value over position_gain_ramp_time ticks of 0.1 ms.
// - in mode 2 the first set is used while the host bit is 0 and the second while it is 1.
// - in mode 3 the block enters the second set above level plus hysteresis and leaves it after the thrust stays below level minus hysteresis for the delay.
package gain_switch_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 100000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] DELAY_OFFSET = 8'h04;
	localparam logic [7:0] LEVEL_OFFSET = 8'h08;
	localparam logic [7:0] HYST_OFFSET = 8'h0c;
	localparam logic [7:0] RAMP_OFFSET = 8'h10;
	localparam logic [7:0] GAIN1_OFFSET = 8'h14;
	localparam logic [7:0] GAIN2_OFFSET = 8'h18;
	localparam logic [7:0] STATUS_OFFSET = 8'h1c;

	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int STATUS_SECOND_BIT = 0;
	localparam int STATUS_P_ONLY_BIT = 1;
	localparam int STATUS_GAIN_LSB = 16;

	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [13:0] DELAY_RESET = 14'h0000;
	localparam logic [14:0] LEVEL_RESET = 15'h0000;
	localparam logic [14:0] HYST_RESET = 15'h0000;
	localparam logic [13:0] RAMP_RESET = 14'h0000;
	localparam logic [15:0] GAIN1_RESET = 16'h0000;
	localparam logic [15:0] GAIN2_RESET = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		MODE_FIX_FIRST = 4'h0,
		MODE_FIX_SECOND = 4'h1,
		MODE_HOST_BIT = 4'h2,
		MODE_THRUST = 4'h3,
		MODE_INVALID = 4'h4,
		MODE_VEL_CMD = 4'h5,
		MODE_DEVIATION = 4'h6,
		MODE_CMD_PRESENT = 4'h7,
		MODE_NOT_SETTLED = 4'h8,
		MODE_SPEED = 4'h9,
		MODE_CMD_AND_SPEED = 4'ha
	} switch_mode_t;

	typedef enum logic {
		SET_FIRST = 1'b0,
		SET_SECOND = 1'b1
	} gain_set_t;

	typedef struct packed {
		logic signed [23:0] thrust_cmd;
		logic signed [23:0] velocity_cmd;
		logic signed [23:0] position_deviation;
		logic signed [23:0] actual_speed;
		logic position_cmd_present;
		logic positioning_complete;
	} motion_status_t;

	typedef struct packed {
		logic second_set_active;
		logic velocity_p_only;
		logic [15:0] position_loop_gain;
	} gain_out_t;

endpackage
